// File: pkg/scp_consts.svh
// constants of the serial configuration memory read-out block
// assumes a single core clock of 125 mhz
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ==========================================================
// storage geometry
`define SCP_WORD_W      32
`define SCP_ADDR_W      4
`define SCP_MEM_WORDS   16
`define SCP_ADDR_MAX    4'hf
`define SCP_BIT_W       5
`define SCP_BIT_LAST    5'h1f
`define SCP_FIFO_DEPTH  32

// ==========================================================
// reset values and polarity codes
`define SCP_POL_RST_LOW 1'b0
`define SCP_POL_RST_HIGH 1'b1
`define SCP_MEM_RST     32'h0000_0000

// ==========================================================
// timing
`define SCP_CLK_NS      8
`define SCP_POR_NS      1000
`define SCP_POR_CYCLES  ((`SCP_POR_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_POR_W       8

`endif

// File: pkg/scp_pkg.sv
// types shared by the read-out block and its test bench
// assumes scp_consts.svh is on the include path
`include "scp_consts.svh"

package scp_pkg;

    typedef logic [`SCP_WORD_W-1:0] scp_word_type;
    typedef logic [`SCP_ADDR_W-1:0] scp_addr_type;

    // programming-side write port
    typedef struct packed {
        logic         we;
        scp_addr_type addr;
        scp_word_type wdata;
        logic         pol_we;
        logic         pol;
    } scp_prog_type;

    typedef enum logic [1:0] {
        SCP_POR,
        SCP_LOAD,
        SCP_PROG
    } scp_mode_type;

endpackage

// File: verilog/scp_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps

module scp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        in_ready  = (cnt_q != (PW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        out_data  = mem_q[rd_q];
        push      = in_valid & in_ready & ~flush;
        pop       = out_valid & out_ready & ~flush;
        wr_d      = push ? PW'(wr_q + 1'b1) : wr_q;
        rd_d      = pop ? PW'(rd_q + 1'b1) : rd_q;
        cnt_d     = cnt_q;
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end else if (push & ~pop) begin
            cnt_d = (PW+1)'(cnt_q + 1'b1);
        end else if (pop & ~push) begin
            cnt_d = (PW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // data storage needs no reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule // scp_fifo

// File: verilog/scp_readout.sv
// read-out control of a serial configuration memory
// assumes all pins synchronous to core_clk; tri-states resolved outside
//
// Function
// - cascade output low once counter passes maximum
// - cascade low, then follows enable, high after
// - device select gates writes only in programming
// - ready pulled low during power-up reset
// - programming select low leaves loading mode
// - reset level clears counter, tri-states data
// - chip enable inactive keeps counter, data off
// - output-enable level with enable drives data
// - data released after all bits shifted out
// - power-up resets address counter automatically
// - config clock edge advances bit counters
// - reset/output-enable polarity set by programming
// - chip enable high stops counters, standby
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_readout (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // fpga loading pins
    input  wire logic                 fpga_config_clock,
    input  wire logic                 chip_enable_n,
    input  wire logic                 reset_oe,
    output logic                      data_out,
    output logic                      data_oe,
    output logic                      cascade_enable_out_n,
    // power-up status, open collector
    output logic                      ready_out,
    output logic                      ready_oe,
    // programming mode
    input  wire logic                 program_mode_select_n,
    input  wire logic                 program_device_select,
    input  wire scp_pkg::scp_prog_type prog_wr
);
    // ==========================================================
    // state
    scp_pkg::scp_mode_type mode_q, mode_d;
    scp_pkg::scp_word_type mem_q [`SCP_MEM_WORDS];
    scp_pkg::scp_word_type sh_q, sh_d, fifo_data;
    scp_pkg::scp_addr_type word_q, word_d, pf_q, pf_d;
    logic [`SCP_BIT_W-1:0] bit_q, bit_d;
    logic [`SCP_POR_W-1:0] por_q, por_d;
    logic sh_vld_q, sh_vld_d, done_q, done_d, pf_done_q, pf_done_d;
    logic pol_q, pol_d, clk_prev_q;
    logic dout_d, doe_d, ceo_d, rdy_oe_d;
    logic rst_act, oe_act, load, clear, run, edge_seen, adv;
    logic wr_en, fifo_in_rdy, fifo_out_vld, pop, push;

    // ==========================================================
    // mode and polarity
    always_comb begin
        rst_act = (pol_q == `SCP_POL_RST_LOW) ? ~reset_oe : reset_oe;
        oe_act  = ~rst_act;
        mode_d  = mode_q;
        por_d   = por_q;
        unique case (mode_q)
            scp_pkg::SCP_POR: begin
                por_d = `SCP_POR_W'(por_q + 1'b1);
                if (por_q == `SCP_POR_W'(`SCP_POR_CYCLES - 1)) begin
                    mode_d = program_mode_select_n ? scp_pkg::SCP_LOAD
                                                   : scp_pkg::SCP_PROG;
                end
            end
            scp_pkg::SCP_LOAD: begin
                if (!program_mode_select_n) begin
                    mode_d = scp_pkg::SCP_PROG;
                end
            end
            scp_pkg::SCP_PROG: begin
                if (program_mode_select_n) begin
                    mode_d = scp_pkg::SCP_LOAD;
                end
            end
        endcase
        load  = (mode_q == scp_pkg::SCP_LOAD) & program_mode_select_n;
        // select only matters while programming
        wr_en = (mode_q == scp_pkg::SCP_PROG) & program_device_select;
        pol_d = (wr_en & prog_wr.pol_we) ? prog_wr.pol : pol_q;
        rdy_oe_d = (mode_d == scp_pkg::SCP_POR);
    end

    // ==========================================================
    // prefetch into fifo; fifo back-pressure stalls it
    always_comb begin
        clear = rst_act | ~load;
        push  = load & ~rst_act & ~pf_done_q;
        pf_d  = pf_q;
        pf_done_d = pf_done_q;
        if (clear) begin
            pf_d      = '0;
            pf_done_d = 1'b0;
        end else if (push & fifo_in_rdy) begin
            pf_d      = scp_pkg::scp_addr_type'(pf_q + 1'b1);
            pf_done_d = (pf_q == `SCP_ADDR_MAX);
        end
    end

    scp_fifo #(
        .WIDTH (`SCP_WORD_W),
        .DEPTH (`SCP_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .flush     (clear),
        .in_valid  (push),
        .in_ready  (fifo_in_rdy),
        .in_data   (mem_q[pf_q]),
        .out_valid (fifo_out_vld),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // ==========================================================
    // bit and address counters
    always_comb begin
        // slow clock taken as a synchronous level, rising edge counts
        edge_seen = fpga_config_clock & ~clk_prev_q;
        run  = load & oe_act & ~chip_enable_n & ~done_q;
        adv  = run & edge_seen & sh_vld_q;
        pop  = ~sh_vld_q & ~clear;
        sh_d = sh_q;
        sh_vld_d = sh_vld_q;
        bit_d  = bit_q;
        word_d = word_q;
        done_d = done_q;
        if (clear) begin
            sh_vld_d = 1'b0;
            bit_d    = '0;
            word_d   = '0;
            done_d   = 1'b0;
        end else if (adv) begin
            sh_d  = {1'b0, sh_q[`SCP_WORD_W-1:1]};
            bit_d = `SCP_BIT_W'(bit_q + 1'b1);
            if (bit_q == `SCP_BIT_LAST) begin
                sh_vld_d = 1'b0;
                word_d   = scp_pkg::scp_addr_type'(word_q + 1'b1);
                done_d   = (word_q == `SCP_ADDR_MAX);
            end
        end else if (pop & fifo_out_vld) begin
            sh_d     = fifo_data;
            sh_vld_d = 1'b1;
        end
        dout_d = sh_q[0];
        // released once done so the next memory may drive
        doe_d  = run & ~clear;
        // low after done while enabled, then follows enable
        ceo_d  = ~(done_q & ~chip_enable_n & oe_act & load);
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q     <= scp_pkg::SCP_POR;
            por_q      <= '0;
            pol_q      <= `SCP_POL_RST_LOW;
            pf_q       <= '0;
            pf_done_q  <= 1'b0;
            sh_q       <= `SCP_MEM_RST;
            sh_vld_q   <= 1'b0;
            bit_q      <= '0;
            word_q     <= '0;
            done_q     <= 1'b0;
            clk_prev_q <= 1'b0;
            data_out   <= 1'b0;
            data_oe    <= 1'b0;
            cascade_enable_out_n <= 1'b1;
            ready_out  <= 1'b0;
            ready_oe   <= 1'b1;
        end else begin
            mode_q     <= mode_d;
            por_q      <= por_d;
            pol_q      <= pol_d;
            pf_q       <= pf_d;
            pf_done_q  <= pf_done_d;
            sh_q       <= sh_d;
            sh_vld_q   <= sh_vld_d;
            bit_q      <= bit_d;
            word_q     <= word_d;
            done_q     <= done_d;
            clk_prev_q <= fpga_config_clock;
            data_out   <= dout_d;
            data_oe    <= doe_d;
            cascade_enable_out_n <= ceo_d;
            ready_out  <= 1'b0;
            ready_oe   <= rdy_oe_d;
        end
    end

    // stored bitstream, written only in programming mode
    always_ff @(posedge core_clk) begin
        if (wr_en & prog_wr.we) begin
            mem_q[prog_wr.addr] <= prog_wr.wdata;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ceo_low_done: assert property (done_q && !chip_enable_n && oe_act && load
        |=> !cascade_enable_out_n) else $error("cascade not low");
    a_ceo_follow_ce: assert property (done_q && oe_act && load ##1 done_q
        |-> cascade_enable_out_n == $past(chip_enable_n))
        else $error("cascade not following enable");
    a_ceo_high_idle: assert property (!done_q |=> cascade_enable_out_n)
        else $error("cascade low before done");
    a_sel_gate_write: assert property (prog_wr.we && !program_device_select
        |-> !wr_en) else $error("write without select");
    a_ready_por: assert property ($rose(mode_q != scp_pkg::SCP_POR)
        |-> !ready_oe ##0 $past(ready_oe, 2))
        else $error("ready wrong around power-up");
    a_prog_no_data: assert property (!program_mode_select_n ##1
        !program_mode_select_n |=> !data_oe)
        else $error("data driven in programming");
    // data enable is checked one cycle on: reset may lift right after
    a_reset_clear: assert property (rst_act |=> word_q == '0 && bit_q == '0
        && !data_oe) else $error("reset did not clear");
    a_standby_hold: assert property (chip_enable_n && !rst_act && load
        && mode_q == $past(mode_q) |=> $stable(word_q) && $stable(bit_q)
        && !data_oe) else $error("counters moved in standby");
    a_oe_drive: assert property (oe_act && !chip_enable_n && load && !done_q
        |=> data_oe) else $error("data not driven");
    a_release_done: assert property (done_q |=> !data_oe)
        else $error("data driven after done");
    a_por_clear: assert property (mode_q == scp_pkg::SCP_POR
        |-> word_q == '0 && !data_oe) else $error("counter live in por");
    a_edge_adv: assert property (adv |=> bit_q == `SCP_BIT_W'($past(bit_q) + 1))
        else $error("edge did not advance");
    a_pol_reset: assert property ((pol_q ? reset_oe : !reset_oe)
        |=> word_q == '0) else $error("polarity reset ignored");
    a_ce_stop: assert property (chip_enable_n && edge_seen |=> !$rose(bit_q[0]))
        else $error("count with enable high");
    a_data_bit: assert property (adv |-> ##1 data_out == $past(sh_q[0]))
        else $error("wrong data bit");

    c_done: cover property (!done_q ##1 done_q);
    c_cascade: cover property (!cascade_enable_out_n);
    c_por_end: cover property ($fell(ready_oe));
    c_prog_write: cover property (wr_en && prog_wr.we);

endmodule // scp_readout

// File: tb/scp_fpga_model.sv
// fpga master serial port model: makes config clock, samples data pin
// assumes the bench pulses go for one cycle; clock idles low between runs
`timescale 1ns/1ps

module scp_fpga_model (
    // clock
    input  wire logic         core_clk,
    // data pin side
    input  wire logic         data_out,
    input  wire logic         data_oe,
    output logic              fpga_config_clock,
    // control from the bench
    input  wire logic         go,
    input  wire logic         slow,
    input  wire logic [9:0]   n_edges,
    output logic              busy,
    output logic [9:0]        n_cap,
    output logic [511:0]      cap
);
    // ====================
    // line and clocking
    logic din;
    logic last_q = 1'b0;
    // released line shows inverse of last bit, never a stale copy
    assign din = data_oe ? data_out : ~last_q;
    always @(posedge core_clk) last_q <= din;
    initial begin
        fpga_config_clock = 1'b0;
        busy = 1'b0;
        n_cap = '0;
        cap = '0;
        forever begin
            @(posedge core_clk);
            if (go) begin
                busy <= 1'b1;
                n_cap <= '0;
                repeat (n_edges) begin
                    // low phase >= 4 cycles, bit taken at its end
                    repeat (slow ? 12 : 4) @(posedge core_clk);
                    cap[n_cap] <= din;
                    n_cap <= n_cap + 10'h1;
                    fpga_config_clock <= 1'b1;
                    repeat (4) @(posedge core_clk);
                    fpga_config_clock <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // scp_fpga_model

// File: tb/scp_readout_test.sv
// self-checking bench for the read-out block, one task per scenario
// assumes scp_consts.svh on the include path, 125 mhz core clock
`timescale 1ns/1ps

module scp_readout_test;
    // ====================
    // signals
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_enable_n = 1'b1;
    logic reset_oe = 1'b0;
    logic program_mode_select_n = 1'b1;
    logic program_device_select = 1'b0;
    logic fpga_config_clock, data_out, data_oe, cascade_enable_out_n;
    logic ready_out, ready_oe, busy;
    scp_pkg::scp_prog_type prog_wr = '0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [9:0] n_edges = 10'h0;
    logic [9:0] n_cap;
    logic [511:0] cap, expv;
    scp_pkg::scp_word_type mem [16];
    logic next_chip_enable_n;
    int fails = 0, n_compared = 0;

    always #4 core_clk = ~core_clk;

    scp_readout i_dut (.core_clk, .rst_n, .fpga_config_clock,
        .chip_enable_n, .reset_oe, .data_out, .data_oe,
        .cascade_enable_out_n, .ready_out, .ready_oe,
        .program_mode_select_n, .program_device_select, .prog_wr);
    scp_fpga_model i_fpga (.core_clk, .data_out, .data_oe,
        .fpga_config_clock, .go, .slow, .n_edges, .busy, .n_cap, .cap);
    // daisy chain: our cascade output is the next memory's enable
    assign next_chip_enable_n = cascade_enable_out_n;

    // ====================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_vec(input string what, input logic [511:0] e,
                           input logic [511:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(input int n, input logic s);
        int i;
        n_edges <= n[9:0];
        slow <= s;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(1);
        for (i = 0; i < 20000 && busy !== 1'b0; i++) tick(1);
        if (busy !== 1'b0) begin
            fails++;
            close_out();
        end
    endtask
    task automatic wr(input int a, input logic sel);
        prog_wr.we <= 1'b1;
        prog_wr.addr <= a[3:0];
        prog_wr.wdata <= sel ? mem[a] : ~mem[a];
        program_device_select <= sel;
        // strobe stays up across back-to-back writes
        tick(1);
    endtask
    task automatic set_pol(input logic p);
        program_mode_select_n <= 1'b0;
        tick(2);
        prog_wr.pol_we <= 1'b1;
        prog_wr.pol <= p;
        program_device_select <= 1'b1;
        tick(1);
        prog_wr.pol_we <= 1'b0;
        program_mode_select_n <= 1'b1;
    endtask

    // ====================
    // scenarios
    task automatic s_por;
        chk_bit("ready_oe", 1'b1, ready_oe);
        chk_bit("ready_out", 1'b0, ready_out);
        chk_bit("data_oe", 1'b0, data_oe);
        tick(118);
        chk_bit("ready_oe", 1'b1, ready_oe);
        tick(12);
        chk_bit("ready_oe", 1'b0, ready_oe);
    endtask
    task automatic s_prog;
        int i;
        program_mode_select_n <= 1'b0;
        chip_enable_n <= 1'b0;
        reset_oe <= 1'b1;
        tick(2);
        for (i = 0; i < 16; i++) begin
            mem[i] = 32'h9e37_79b9 ^ {8{i[3:0]}};
            expv[i*32 +: 32] = mem[i];
            wr(i, 1'b0);
            wr(i, 1'b1);
        end
        prog_wr.we <= 1'b0;
        chk_bit("data_oe", 1'b0, data_oe);
        chk_bit("cascade", 1'b1, cascade_enable_out_n);
        program_mode_select_n <= 1'b1;
        reset_oe <= 1'b0;
        chip_enable_n <= 1'b1;
        tick(2);
    endtask
    task automatic s_fifo;
        // words queue up inside while the master holds off in standby
        reset_oe <= 1'b1;
        tick(40);
        chk_bit("data_oe", 1'b0, data_oe);
        chk_bit("first bit", expv[0], data_out);
        chip_enable_n <= 1'b0;
        tick(2);
        run(64, 1'b0);
        chk_vec("two words", 512'(expv[63:0]), 512'(cap[63:0]));
        reset_oe <= 1'b0;
        chip_enable_n <= 1'b1;
        tick(2);
    endtask
    task automatic s_read;
        reset_oe <= 1'b1;
        run(8, 1'b0);
        chk_bit("data_oe", 1'b0, data_oe);
        chip_enable_n <= 1'b0;
        tick(6);
        chk_bit("data_oe", 1'b1, data_oe);
        chk_bit("cascade", 1'b1, cascade_enable_out_n);
        run(512, 1'b0);
        chk_vec("stream", expv, cap);
        tick(4);
        chk_bit("cascade", 1'b0, cascade_enable_out_n);
        chk_bit("next ce_n", 1'b0, next_chip_enable_n);
        chk_bit("data_oe", 1'b0, data_oe);
    endtask
    task automatic s_cascade;
        chip_enable_n <= 1'b1;
        tick(3);
        chk_bit("cascade", 1'b1, cascade_enable_out_n);
        chip_enable_n <= 1'b0;
        tick(3);
        chk_bit("cascade", 1'b0, cascade_enable_out_n);
        reset_oe <= 1'b0;
        tick(3);
        chk_bit("cascade", 1'b1, cascade_enable_out_n);
        chk_bit("data_oe", 1'b0, data_oe);
        reset_oe <= 1'b1;
        tick(6);
        chk_bit("cascade", 1'b1, cascade_enable_out_n);
        chk_bit("data_oe", 1'b1, data_oe);
    endtask
    task automatic s_abort;
        run(40, 1'b0);
        chk_vec("head", 512'(expv[39:0]), 512'(cap[39:0]));
        reset_oe <= 1'b0;
        tick(3);
        chk_bit("data_oe", 1'b0, data_oe);
        reset_oe <= 1'b1;
        tick(6);
        run(40, 1'b1);
        chk_vec("head", 512'(expv[39:0]), 512'(cap[39:0]));
    endtask
    task automatic s_pol;
        set_pol(1'b1);
        reset_oe <= 1'b1;
        tick(3);
        chk_bit("data_oe", 1'b0, data_oe);
        reset_oe <= 1'b0;
        tick(6);
        chk_bit("data_oe", 1'b1, data_oe);
        run(40, 1'b0);
        chk_vec("head", 512'(expv[39:0]), 512'(cap[39:0]));
    endtask

    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        s_por();
        s_prog();
        s_fifo();
        s_read();
        s_cascade();
        s_abort();
        s_pol();
        close_out();
    end
endmodule // scp_readout_test
